// File: rtl/rpb_consts.svh
`ifndef RPB_CONSTS_SVH
`define RPB_CONSTS_SVH
// ==========================================================
// Register map, byte addresses
`define RPB_ADDR_CTRL      8'h00
`define RPB_ADDR_STAT      8'h04
`define RPB_ADDR_CAUSE     8'h08
// Control register fields
`define RPB_CTRL_SWBO_BIT  7
`define RPB_CTRL_RST       1'b1
// Status register fields
`define RPB_STAT_RDY_BIT   0
`define RPB_STAT_CORE_BIT  1
`define RPB_STAT_SLP_BIT   2
// Brown-out mode codes
`define RPB_MODE_ON        2'h3
`define RPB_MODE_AWAKE     2'h2
`define RPB_MODE_SW        2'h1
`define RPB_MODE_OFF       2'h0
// Timing: 64 ms of a 31 kHz low-frequency tick
`define RPB_PWRUP_MS       64
`define RPB_LF_HZ          31000
`define RPB_PWRUP_TICKS    ((`RPB_PWRUP_MS * `RPB_LF_HZ) / 1000)
// Brown-out rejection interval in ns, and count at 25 ns per cycle
`define RPB_REJECT_NS      2000
`define RPB_CLK_NS         25
`define RPB_REJECT_CYC     ((`RPB_REJECT_NS + `RPB_CLK_NS - 1) / `RPB_CLK_NS)
`endif

// File: rtl/rpb_pkg.sv
package rpb_pkg;
    // ======================================================
    // Sequencer states
    typedef enum logic [1:0] {
        ST_HOLD = 2'b00,
        ST_WAIT = 2'b01,
        ST_TIME = 2'b10,
        ST_RUN  = 2'b11
    } rpb_state_t;
endpackage : rpb_pkg

// File: rtl/rpb_sync_if.sv
`timescale 1ns/100ps
interface rpb_sync_if;
    logic [3:0] raw;
    logic [3:0] clean;
    modport src (output raw, input clean);
    modport snk (input raw, output clean);
endinterface : rpb_sync_if

// File: rtl/rpb_sync.sv
`timescale 1ns/100ps
module rpb_sync (
    input  wire logic mclk_i,
    input  wire logic reset_i,
    rpb_sync_if.snk   sif
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
        logic [3:0] cl;
    } rpb_sync_st_t;
    rpb_sync_st_t st_r;
    rpb_sync_st_t st_nxt;
    // ======================================================
    // Three stages, accept a change once stages two and three agree
    always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = sif.raw;
        st_nxt.s2 = st_r.s1;
        st_nxt.s3 = st_r.s2;
        for (int i = 0; i < 4; i++) begin
            if (st_r.s2[i] == st_r.s3[i]) begin
                st_nxt.cl[i] = st_r.s3[i];
            end
        end
    end
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end
    assign sif.clean = st_r.cl;
endmodule : rpb_sync

// File: rtl/rpb_reset_ctrl.sv
`timescale 1ns/100ps
`include "rpb_consts.svh"
module rpb_reset_ctrl (
    input  wire logic        mclk_i,
    input  wire logic        reset_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Configuration straps
    input  wire logic [1:0]  brownout_mode_sel_i,
    input  wire logic        powerup_delay_enable_n_i,
    input  wire logic        brownout_level_sel_i,
    input  wire logic        ext_reset_enable_i,
    // Analog and pin inputs
    input  wire logic        por_good_i,
    input  wire logic        brownout_low_i,
    input  wire logic        brownout_ready_i,
    input  wire logic        external_reset_pin_n_i,
    input  wire logic        lf_tick_i,
    // Same-clock reset requests and core state
    input  wire logic        watchdog_timer_rst_i,
    input  wire logic        reset_instr_i,
    input  wire logic        stack_ovf_i,
    input  wire logic        stack_unf_i,
    input  wire logic        prog_exit_i,
    input  wire logic        sleep_i,
    input  wire logic        osc_ready_i,
    // Outputs
    output logic             core_reset_o,
    output logic             brownout_det_en_o,
    output logic             brownout_level_sel_o,
    output logic             wake_hold_o
);
    localparam logic [15:0] PWRUP_TICKS = 16'(`RPB_PWRUP_TICKS);
    localparam logic [7:0]  REJECT_CYC  = 8'(`RPB_REJECT_CYC);

    typedef struct packed {
        rpb_pkg::rpb_state_t state;
        logic [15:0]         pwr_cnt;
        logic [7:0]          low_cnt;
        logic                sw_en;
        logic                bo_trip;
        logic                core_rst;
        logic                det_en;
        logic                lvl;
        logic                wake_hold;
        logic [7:0]          cause;
        logic                ack;
        logic [31:0]         dat;
    } rpb_st_t;
    rpb_st_t st_r;
    rpb_st_t st_nxt;

    // ======================================================
    // Synchronisers for the power-good, brown-out low, pin and low-frequency tick inputs; brownout_ready_i is used unsynchronised
    rpb_sync_if sif ();
    rpb_sync u_sync (
        .mclk_i  (mclk_i),
        .reset_i (reset_i),
        .sif     (sif)
    );
    assign sif.raw = {lf_tick_i, external_reset_pin_n_i, brownout_low_i, por_good_i};
    logic por_ok;
    logic bo_low;
    logic pin_n;
    logic lf_lvl;
    logic lf_prev_r;
    logic lf_rise;
    assign por_ok = sif.clean[0];
    assign bo_low = sif.clean[1];
    assign pin_n  = sif.clean[2];
    assign lf_lvl = sif.clean[3];
    assign lf_rise = lf_lvl & ~lf_prev_r;
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            lf_prev_r <= 1'b0;
        end else begin
            lf_prev_r <= lf_lvl;
        end
    end

    // ======================================================
    // Detector enable per mode
    function automatic logic det_on(input logic [1:0] m, input logic sw, input logic slp);
        logic r;
        r = 1'b0;
        if (m == `RPB_MODE_ON) begin
            r = 1'b1;
        end else if (m == `RPB_MODE_AWAKE) begin
            r = ~slp;
        end else if (m == `RPB_MODE_SW) begin
            r = sw;
        end else begin
            r = 1'b0;
        end
        return r;
    endfunction : det_on

    logic det_now;
    logic start_wait;
    logic ext_hold;
    logic sw_reset;
    logic bo_prot;
    logic wr;
    logic rd;
    logic [7:0] cause_set;
    assign det_now    = det_on(brownout_mode_sel_i, st_r.sw_en, sleep_i);
    assign start_wait = brownout_mode_sel_i[1];
    assign ext_hold   = ext_reset_enable_i & ~pin_n;
    assign sw_reset   = watchdog_timer_rst_i | reset_instr_i | stack_ovf_i
                      | stack_unf_i | prog_exit_i;
    assign bo_prot    = det_now & brownout_ready_i;
    // Write lands at the edge where the master sees ack high
    assign wr = wb_cyc_i & wb_stb_i & wb_we_i & st_r.ack;
    // Cause events of this cycle, so a same-cycle set beats a clear
    assign cause_set = {prog_exit_i, stack_unf_i, stack_ovf_i, reset_instr_i,
                        watchdog_timer_rst_i, ext_hold, st_r.bo_trip & por_ok, ~por_ok};
    assign rd = wb_cyc_i & wb_stb_i & ~wb_we_i & ~st_r.ack;

    // ======================================================
    // Next state
    always_comb begin
        st_nxt        = st_r;
        st_nxt.det_en = det_now;
        st_nxt.lvl    = brownout_level_sel_i;
        // Rejection filter on the low-supply indication
        if (bo_prot && bo_low) begin
            if (st_r.low_cnt != REJECT_CYC) begin
                st_nxt.low_cnt = st_r.low_cnt + 8'h01;
            end
        end else begin
            st_nxt.low_cnt = 8'h00;
        end
        st_nxt.bo_trip = bo_prot && bo_low && (st_r.low_cnt == REJECT_CYC);
        // Wake from sleep waits for ready only in awake-only mode
        st_nxt.wake_hold = (brownout_mode_sel_i == `RPB_MODE_AWAKE)
                         && !brownout_ready_i;
        case (st_r.state)
            rpb_pkg::ST_HOLD: begin
                if (por_ok) begin
                    st_nxt.state = rpb_pkg::ST_WAIT;
                end
            end
            rpb_pkg::ST_WAIT: begin
                // Start-up qualification by brown-out readiness
                if (!start_wait || (brownout_ready_i && !bo_low)) begin
                    st_nxt.pwr_cnt = 16'h0000;
                    st_nxt.state   = rpb_pkg::ST_TIME;
                end
            end
            rpb_pkg::ST_TIME: begin
                if (powerup_delay_enable_n_i) begin
                    st_nxt.state = rpb_pkg::ST_RUN;
                end else if (st_r.pwr_cnt == PWRUP_TICKS) begin
                    st_nxt.state = rpb_pkg::ST_RUN;
                end else if (lf_rise) begin
                    st_nxt.pwr_cnt = st_r.pwr_cnt + 16'h0001;
                end
            end
            rpb_pkg::ST_RUN: begin
                st_nxt.state = rpb_pkg::ST_RUN;
            end
            default: begin
                st_nxt.state = rpb_pkg::ST_HOLD;
            end
        endcase
        if (!por_ok) begin
            st_nxt.state   = rpb_pkg::ST_HOLD;
            st_nxt.cause[0] = 1'b1;
        end else if (st_r.bo_trip) begin
            st_nxt.state   = rpb_pkg::ST_WAIT;
            st_nxt.cause[1] = 1'b1;
        end
        if (ext_hold) begin
            st_nxt.cause[2] = 1'b1;
        end
        if (sw_reset) begin
            st_nxt.cause[7:3] = st_r.cause[7:3] | {prog_exit_i, stack_unf_i, stack_ovf_i,
                                                   reset_instr_i, watchdog_timer_rst_i};
        end
        // Core runs only when sequence done, oscillator and pin ready
        st_nxt.core_rst = (st_nxt.state != rpb_pkg::ST_RUN) || !osc_ready_i
                        || ext_hold || sw_reset;
        // Register access, one-cycle ack
        st_nxt.ack = wb_cyc_i & wb_stb_i & ~st_r.ack;
        st_nxt.dat = 32'h0000_0000;
        if (wr && wb_sel_i[0]) begin
            if (wb_adr_i == `RPB_ADDR_CTRL) begin
                st_nxt.sw_en = wb_dat_i[`RPB_CTRL_SWBO_BIT];
            end else if (wb_adr_i == `RPB_ADDR_CAUSE) begin
                st_nxt.cause = (st_r.cause & ~wb_dat_i[7:0]) | cause_set;
            end
        end
        if (rd) begin
            if (wb_adr_i == `RPB_ADDR_CTRL) begin
                st_nxt.dat[`RPB_CTRL_SWBO_BIT] = st_r.sw_en;
                st_nxt.dat[0] = bo_prot;
            end else if (wb_adr_i == `RPB_ADDR_STAT) begin
                st_nxt.dat[`RPB_STAT_RDY_BIT]  = bo_prot;
                st_nxt.dat[`RPB_STAT_CORE_BIT] = st_r.core_rst;
                st_nxt.dat[`RPB_STAT_SLP_BIT]  = sleep_i;
            end else if (wb_adr_i == `RPB_ADDR_CAUSE) begin
                st_nxt.dat[7:0] = st_r.cause;
            end else begin
                st_nxt.dat = 32'h0000_0000;
            end
        end
    end

    // ======================================================
    // State register
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            st_r          <= '0;
            st_r.sw_en    <= `RPB_CTRL_RST;
            st_r.core_rst <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign wb_dat_o             = st_r.dat;
    assign wb_ack_o             = st_r.ack;
    assign core_reset_o         = st_r.core_rst;
    assign brownout_det_en_o    = st_r.det_en;
    assign brownout_level_sel_o = st_r.lvl;
    assign wake_hold_o          = st_r.wake_hold;

    // ======================================================
    // Checks
    sequence s_low_held;
        bo_prot && bo_low;
    endsequence
    AST_CORE_HELD_NO_POR: assert property (@(posedge mclk_i) disable iff (reset_i)
        !por_ok |=> core_reset_o) else $error("core ran without power good");
    AST_TIMER_HOLDS: assert property (@(posedge mclk_i) disable iff (reset_i)
        (st_r.state == rpb_pkg::ST_TIME) && !powerup_delay_enable_n_i
        && (st_r.pwr_cnt != PWRUP_TICKS) |=> core_reset_o)
        else $error("core ran in delay");
    AST_NO_DELAY_WHEN_OFF: assert property (@(posedge mclk_i) disable iff (reset_i)
        (st_r.state == rpb_pkg::ST_TIME) && powerup_delay_enable_n_i
        |=> st_r.state != rpb_pkg::ST_TIME) else $error("disabled delay ran");
    AST_MODE_OFF_DET: assert property (@(posedge mclk_i) disable iff (reset_i)
        (brownout_mode_sel_i == `RPB_MODE_OFF) |=> !brownout_det_en_o)
        else $error("detector on in off mode");
    AST_MODE_ON_DET: assert property (@(posedge mclk_i) disable iff (reset_i)
        (brownout_mode_sel_i == `RPB_MODE_ON) |=> brownout_det_en_o)
        else $error("detector off in on mode");
    AST_AWAKE_SLEEP: assert property (@(posedge mclk_i) disable iff (reset_i)
        (brownout_mode_sel_i == `RPB_MODE_AWAKE) && sleep_i |=> !brownout_det_en_o)
        else $error("detector on in sleep");
    AST_SW_MODE: assert property (@(posedge mclk_i) disable iff (reset_i)
        (brownout_mode_sel_i == `RPB_MODE_SW) |=> brownout_det_en_o == $past(st_r.sw_en))
        else $error("software enable ignored");
    AST_SHORT_DIP: assert property (@(posedge mclk_i) disable iff (reset_i)
        (bo_prot && bo_low && st_r.low_cnt == 8'h00) |=> !st_r.bo_trip)
        else $error("short dip tripped");
    AST_LONG_DIP: assert property (@(posedge mclk_i) disable iff (reset_i)
        s_low_held [*8] ##0 (st_r.low_cnt == REJECT_CYC) |=> st_r.bo_trip)
        else $error("long dip missed");
    AST_EXT_PIN: assert property (@(posedge mclk_i) disable iff (reset_i)
        ext_hold |=> core_reset_o) else $error("pin reset ignored");
    AST_SW_RESET: assert property (@(posedge mclk_i) disable iff (reset_i)
        sw_reset |=> core_reset_o) else $error("reset source ignored");
endmodule : rpb_reset_ctrl

// File: tb/rpb_far_model.sv
`timescale 1ns/100ps
// ==========================================================
// Supply comparators, detector and low-frequency oscillator
module rpb_far_model #(
    parameter int LF_HALF   = 4,
    parameter int READY_DLY = 10
) (
    input  wire logic        mclk_i,
    input  wire logic [11:0] vdd_mv_i,
    input  wire logic        det_en_i,
    input  wire logic        level_sel_i,
    output logic             por_good_o,
    output logic             brownout_low_o,
    output logic             brownout_ready_o,
    output logic             lf_tick_o
);
    int lf_cnt  = 0;
    int rdy_cnt = 0;
    // Comparators on the modelled supply
    assign por_good_o       = (vdd_mv_i >= 12'h3e8);
    assign brownout_low_o   = (vdd_mv_i < (level_sel_i ? 12'h9c4 : 12'h76c));
    assign brownout_ready_o = (rdy_cnt == READY_DLY);
    initial lf_tick_o = 1'b0;
    // Ready settles after enable; fast free-running tick
    always @(posedge mclk_i) begin
        rdy_cnt <= det_en_i ? ((rdy_cnt < READY_DLY) ? rdy_cnt + 1 : rdy_cnt) : 0;
        lf_cnt  <= (lf_cnt == LF_HALF - 1) ? 0 : lf_cnt + 1;
        if (lf_cnt == LF_HALF - 1) begin
            lf_tick_o <= ~lf_tick_o;
        end
    end
endmodule : rpb_far_model

// File: tb/rpb_reset_ctrl_test.sv
`timescale 1ns/100ps
module rpb_reset_ctrl_test;
    logic        mclk_i = 0, reset_i = 1, cyc = 0, stb = 0, we = 0;
    logic [7:0]  adr = 0;
    logic [31:0] wdat = 0, rdat, q;
    logic [1:0]  mode = 3;
    logic        en_n = 1, lvl = 0, ext_en = 0, pin_n = 1, slp = 0, osc = 1, ack;
    logic [4:0]  pls = 0;
    logic [11:0] vdd = 0;
    logic        por, low, rdy, tick, core, det, lvl_o, hold;
    int          errors = 0, tests_run = 0, seed = 32'h4221ff3c;
    rpb_reset_ctrl u_dut (.mclk_i(mclk_i), .reset_i(reset_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .brownout_mode_sel_i(mode), .powerup_delay_enable_n_i(en_n),
        .brownout_level_sel_i(lvl), .ext_reset_enable_i(ext_en), .por_good_i(por),
        .brownout_low_i(low), .brownout_ready_i(rdy), .external_reset_pin_n_i(pin_n),
        .lf_tick_i(tick), .watchdog_timer_rst_i(pls[0]), .reset_instr_i(pls[1]),
        .stack_ovf_i(pls[2]), .stack_unf_i(pls[3]), .prog_exit_i(pls[4]), .sleep_i(slp),
        .osc_ready_i(osc), .core_reset_o(core), .brownout_det_en_o(det),
        .brownout_level_sel_o(lvl_o), .wake_hold_o(hold));
    rpb_far_model u_far (.mclk_i(mclk_i), .vdd_mv_i(vdd), .det_en_i(det), .level_sel_i(lvl_o),
        .por_good_o(por), .brownout_low_o(low), .brownout_ready_o(rdy), .lf_tick_o(tick));
    // Clock
    initial forever #12.5 mclk_i = ~mclk_i;
    // Compare and count
    task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk
    task cyc_n(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : cyc_n
    // Classic single Wishbone cycle
    task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk_i);
        cyc <= 1; stb <= 1; we <= w; adr <= a; wdat <= d;
        do begin
            @(posedge mclk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        chk(ack, 1, "bus ack");
        cyc <= 0; stb <= 0; we <= 0;
    endtask : wb
    task do_reset(input logic [1:0] m, input logic e);
        mode <= m; en_n <= e; reset_i <= 1;
        cyc_n(20);
        reset_i <= 0;
        cyc_n(1);
    endtask : do_reset
    // Bounded wait for a core reset level
    task wait_core(input logic v, input int lim);
        int n;
        n = 0;
        while (core !== v && n < lim) begin
            @(posedge mclk_i);
            n++;
        end
        chk(core, v, "core reset");
    endtask : wait_core
    task close_out;
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    // Watchdog
    initial begin
        #1000000;
        errors++;
        close_out();
    end
    // Main sequence
    initial begin
        do_reset(2'h3, 1);
        chk(core, 1, "por low");
        wb(0, 8'h00, 0);
        chk(q[7], 1, "sw enable reset");
        wb(0, 8'h0c, 0);
        chk(q, 0, "unmapped read");
        cyc_n(30);
        chk(core, 1, "por low hold");
        vdd <= 12'hbb8;
        wait_core(0, 60);
        slp <= 1;
        cyc_n(20);
        chk({det, hold}, 2'b10, "mode 11 sleep");
        slp <= 0;
        $display("Test power-up done");
        vdd <= 12'h708;
        cyc_n(40);
        vdd <= 12'hbb8;
        cyc_n(10);
        chk(core, 0, "short dip");
        vdd <= 12'h708;
        cyc_n(120);
        chk(core, 1, "long dip");
        vdd <= 12'hbb8;
        wait_core(0, 60);
        wb(0, 8'h08, 0);
        chk(q[1], 1, "brownout cause");
        wb(1, 8'h08, 32'hff);
        lvl <= 1'($random(seed));
        cyc_n(3);
        chk(lvl_o, lvl, "level copy");
        lvl <= 1;
        vdd <= 12'h898;
        cyc_n(120);
        chk(core, 1, "high level trips");
        lvl <= 0;
        wait_core(0, 60);
        vdd <= 12'hbb8;
        $display("Test brown-out done");
        for (int i = 0; i < 5; i++) begin
            pls <= 5'h01 << i;
            @(posedge mclk_i);
            pls <= 0;
            wait_core(1, 4);
            wait_core(0, 60);
            wb(0, 8'h08, 0);
            chk(q[3 + i], 1, "source cause");
            wb(1, 8'h08, 32'hff);
        end
        ext_en <= 1; pin_n <= 0;
        cyc_n(20);
        chk(core, 1, "pin held");
        pin_n <= 1;
        wait_core(0, 20);
        ext_en <= 0; pin_n <= 0;
        cyc_n(20);
        chk(core, 0, "pin disabled");
        pin_n <= 1; osc <= 0;
        cyc_n(10);
        chk(core, 1, "osc not ready");
        osc <= 1;
        wait_core(0, 20);
        $display("Test sources done");
        do_reset(2'h2, 1);
        wait_core(0, 60);
        slp <= 1;
        cyc_n(20);
        chk({det, hold}, 2'b01, "mode 10 sleep");
        slp <= 0;
        cyc_n(30);
        chk({det, hold}, 2'b10, "mode 10 wake");
        do_reset(2'h1, 1);
        vdd <= 12'h708;
        wait_core(0, 60);
        wait_core(1, 150);
        wb(1, 8'h00, 0);
        wait_core(0, 60);
        wb(0, 8'h00, 0);
        chk({q[7], q[0], det}, 3'b000, "sw disable");
        vdd <= 12'hbb8;
        wb(1, 8'h00, 32'h80);
        cyc_n(20);
        slp <= 1;
        cyc_n(5);
        chk(det, 1, "sw mode sleep");
        wb(0, 8'h00, 0);
        chk(q[0], 1, "ready flag");
        slp <= 0;
        do_reset(2'h0, 1);
        wb(1, 8'h00, 32'h80);
        cyc_n(5);
        chk(det, 0, "mode 00 off");
        wait_core(0, 60);
        $display("Test modes done");
        do_reset(2'h3, 0);
        vdd <= 12'h708;
        cyc_n(3000);
        chk(core, 1, "no count in brown-out");
        vdd <= 12'hbb8;
        cyc_n(1984 * 8 - 200);
        chk(core, 1, "delay counting");
        wait_core(0, 600);
        $display("Test delay done");
        close_out();
    end
endmodule : rpb_reset_ctrl_test
